//--- verilog/quhsr_host_front.sv
// Purpose: Host bus front end of a four channel serial controller
// Assumes: Bus pins synchronous to clk_sys; strobes held >= 2 cycles
// Notes:   Read data is registered, one cycle after the strobe
//
// How it works
// - Transmit idles high, or low in infrared
// - Polarity bit selects infrared receive mark level
// - Strap active high, sampled at every reset
// - Sampled strap lands in infrared control bit
// - Bus style pin selects strobe interpretation
// - Hardware reset returns registers and outputs
// - Soft reset write resets the chosen channels
// - Chip select low is required for access
// - Two address bits pick channel zero to three
// - Broadcast bit writes all four channels
// - Timer may count the external timer clock
// - Modem inputs active low, readable as inputs
// - Modem outputs active low, drivable as outputs
`timescale 1ns/1ps
module quhsr_host_front
    import quhsr_pkg::*;
#(
    parameter int TMR_W = TMR_WIDTH   // Timer counter width
)(
    input  wire logic              clk_sys,              // 250 MHz clock
    input  wire logic              resetn,               // Async, low
    input  wire logic              chip_sel_n,           // Chip select
    input  wire logic              read_strobe_n,        // Read strobe
    input  wire logic              write_strobe_n,       // Write strobe
    input  wire logic              bus_style,            // 1 first style
    input  wire logic [ADDR_W-1:0] addr,                 // Address lines
    input  wire logic [DATA_W-1:0] data_in,              // Bus data in
    output logic      [DATA_W-1:0] data_out,             // Bus data out
    output logic                   data_oe,              // Bus drive
    input  wire logic              infrared_strap,       // Strap pin
    input  wire logic              timer_ext_clock,      // Timer clock
    input  wire logic [NUM_CH-1:0] serial_in_ch,         // Receive
    input  wire logic [NUM_CH-1:0] send_clear_n_ch,      // Clear to send
    input  wire logic [NUM_CH-1:0] set_ready_n_ch,       // Set ready
    input  wire logic [NUM_CH-1:0] carrier_detect_n_ch,  // Carrier
    input  wire logic [NUM_CH-1:0] ring_indicator_n_ch,  // Ring
    output logic      [NUM_CH-1:0] serial_out_ch,        // Transmit
    output logic      [NUM_CH-1:0] send_request_n_ch,    // Request send
    output logic      [NUM_CH-1:0] terminal_ready_n_ch,  // Terminal rdy
    output logic      [NUM_CH-1:0] rx_mark_ch,           // Decoded rx
    output logic                   bcast_mode            // Broadcast on
);

    logic              wr_act;
    logic              rd_act;
    logic              wr_q_r;
    logic              wr_pulse;
    logic              dev_space;
    logic [NUM_CH-1:0] ch_hit;
    logic [NUM_CH-1:0] ch_wr;
    logic [NUM_CH-1:0] srst_r;
    logic              init_done_r;
    logic              bcast_r;
    logic [DATA_W-1:0] tmr_ctrl_r;
    logic [TMR_W-1:0]  tmr_cnt_r;
    logic              tmr_q_r;
    logic              tmr_tick;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] ch_rdata [NUM_CH];

    // One-hot channel select; reserved encoding yields no channel
    function automatic logic [NUM_CH-1:0] chan_hit(
        input logic [ADDR_W-1:0] a
    );
        logic [NUM_CH-1:0] hit;
        hit = '0;
        if (!a[ADDR_DEV_BIT] && !a[ADDR_RSV_BIT])
            hit[a[ADDR_CH_HI:ADDR_CH_LO]] = 1'b1;
        return hit;
    endfunction : chan_hit

    // Strobe decode: first style has separate read and write strobes;
    // second style uses chip select as strobe and write pin as R/W
    assign wr_act = !chip_sel_n && !write_strobe_n;
    assign rd_act = !chip_sel_n &&
                    (bus_style ? !read_strobe_n : write_strobe_n);
    assign wr_pulse  = wr_act && !wr_q_r;
    assign dev_space = addr[ADDR_DEV_BIT];
    assign ch_hit    = chan_hit(addr);
    // Broadcast widens a channel write; reserved space still blocked
    assign ch_wr = !wr_pulse ? '0 :
                   (bcast_r && |ch_hit) ? '1 : ch_hit;

    // Write edge detect so a long strobe writes once
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            wr_q_r <= 1'b0;
        else
            wr_q_r <= wr_act;
    end

    // Strap sampled after hardware reset and on each soft reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            init_done_r <= 1'b0;
            srst_r      <= '0;
        end else begin
            init_done_r <= 1'b1;
            if (wr_pulse && addr == OFF_SOFT_RESET)
                srst_r <= data_in[NUM_CH-1:0];
            else
                srst_r <= '0;
        end
    end

    // Device-level control registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bcast_r    <= 1'b0;
            tmr_ctrl_r <= ZERO8;
        end else if (wr_pulse) begin
            if (addr == OFF_BCAST_CTRL) bcast_r    <= data_in[BCAST_BIT];
            if (addr == OFF_TMR_CTRL)   tmr_ctrl_r <= data_in;
        end else begin
            tmr_ctrl_r[TMR_CLR_BIT] <= 1'b0;  // Clear is a pulse
        end
    end

    // Timer counts system clocks or rising edges of the timer pin;
    // pin treated as synchronous, so one edge detector suffices
    assign tmr_tick = tmr_ctrl_r[TMR_EXT_BIT] ? (timer_ext_clock &&
                      !tmr_q_r) : 1'b1;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tmr_q_r   <= 1'b0;
            tmr_cnt_r <= '0;
        end else begin
            tmr_q_r <= timer_ext_clock;
            if (tmr_ctrl_r[TMR_CLR_BIT])
                tmr_cnt_r <= '0;
            else if (tmr_ctrl_r[TMR_EN_BIT] && tmr_tick)
                tmr_cnt_r <= tmr_cnt_r + 1'b1;
        end
    end

    // Channels
    quhsr_chan_if ch_if [NUM_CH] ();
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_if[g].wr_en      = ch_wr[g];
        assign ch_if[g].reg_addr   = addr[REG_W-1:0];
        assign ch_if[g].wdata      = data_in;
        assign ch_if[g].strap_load = srst_r[g] || !init_done_r;
        assign ch_if[g].strap      = infrared_strap;
        assign ch_rdata[g]         = ch_if[g].rdata;
        quhsr_chan u_chan (
            .clk_sys          (clk_sys),
            .resetn           (resetn),
            .bus              (ch_if[g]),
            .serial_in        (serial_in_ch[g]),
            .send_clear_n     (send_clear_n_ch[g]),
            .set_ready_n      (set_ready_n_ch[g]),
            .carrier_detect_n (carrier_detect_n_ch[g]),
            .ring_indicator_n (ring_indicator_n_ch[g]),
            .serial_out       (serial_out_ch[g]),
            .send_request_n   (send_request_n_ch[g]),
            .terminal_ready_n (terminal_ready_n_ch[g]),
            .rx_mark          (rx_mark_ch[g])
        );
    end

    // Read mux; unmapped and reserved addresses read zero
    always_comb begin
        rd_mux = ZERO8;
        if (dev_space) begin
            unique case (addr)
                OFF_BCAST_CTRL: rd_mux[BCAST_BIT] = bcast_r;
                OFF_TMR_CTRL:   rd_mux = tmr_ctrl_r;
                OFF_TMR_LSB:    rd_mux = tmr_cnt_r[DATA_W-1:0];
                OFF_TMR_MSB:    rd_mux = tmr_cnt_r[TMR_W-1:DATA_W];
                default:        rd_mux = ZERO8;
            endcase
        end else begin
            for (int i = 0; i < NUM_CH; i++)
                if (ch_hit[i]) rd_mux = ch_rdata[i];
        end
    end

    // Registered bus outputs; drive only while a read is active
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_out   <= ZERO8;
            data_oe    <= 1'b0;
            bcast_mode <= 1'b0;
        end else begin
            data_out   <= rd_act ? rd_mux : ZERO8;
            data_oe    <= rd_act;
            bcast_mode <= bcast_r;
        end
    end

    // Write cycle seen on the pins with chip select low
    sequence s_bcast_wr;
        wr_pulse && bcast_r && !dev_space && !addr[ADDR_RSV_BIT];
    endsequence
    sequence s_soft_rst;
        wr_pulse && addr == OFF_SOFT_RESET;
    endsequence

    AST_CS_GATE: assert property (@(posedge clk_sys) disable iff (!resetn)
        chip_sel_n |-> ch_wr == '0 ##1 !data_oe)
        else $error("bus acted on with chip select high");

    AST_STYLE: assert property (@(posedge clk_sys) disable iff (!resetn)
        !bus_style && !chip_sel_n && write_strobe_n |=> data_oe)
        else $error("second bus style read not driven");

    AST_CH_DEC: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_pulse && !bcast_r && !addr[ADDR_DEV_BIT] && !addr[ADDR_RSV_BIT]
        |-> ch_wr == (4'h1 << addr[ADDR_CH_HI:ADDR_CH_LO]))
        else $error("channel decode wrong");

    AST_RSV: assert property (@(posedge clk_sys) disable iff (!resetn)
        !addr[ADDR_DEV_BIT] && addr[ADDR_RSV_BIT] |-> ch_wr == '0)
        else $error("reserved encoding wrote a channel");

    AST_BCAST: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_bcast_wr |-> ch_wr == '1)
        else $error("broadcast did not reach all channels");

    AST_SRST_STRAP: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        s_soft_rst ##1 srst_r[0] |=> g_ch[0].u_chan.mcr_r[MCR_IR_BIT]
        == $past(infrared_strap))
        else $error("soft reset did not sample strap");

    AST_SRST_SEL: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_soft_rst |=> srst_r == $past(data_in[NUM_CH-1:0]) ##1
        srst_r == '0)
        else $error("soft reset channel select wrong");

    AST_HW_INIT: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(init_done_r) |-> !bcast_r && !bcast_mode &&
        tmr_ctrl_r == ZERO8 && tmr_cnt_r == '0)
        else $error("state after hardware reset wrong");

    AST_STRAP_POR: assert property (@(posedge clk_sys) disable iff (!resetn)
        !init_done_r |=> g_ch[1].u_chan.mcr_r[MCR_IR_BIT]
        == $past(infrared_strap))
        else $error("strap not sampled after reset");

    AST_TMR_EXT: assert property (@(posedge clk_sys) disable iff (!resetn)
        tmr_ctrl_r[TMR_EN_BIT] && tmr_ctrl_r[TMR_EXT_BIT] &&
        !tmr_ctrl_r[TMR_CLR_BIT] && !timer_ext_clock
        |=> tmr_cnt_r == $past(tmr_cnt_r))
        else $error("timer advanced without external edge");

    AST_MODEM_IN: assert property (@(posedge clk_sys) disable iff (!resetn)
        rd_act && addr == {4'h0, OFF_MODEM_STAT}
        |=> data_out[MSR_CTS_BIT] == !$past(send_clear_n_ch[0]))
        else $error("modem input not read active high");

endmodule : quhsr_host_front

//--- common/quhsr_pkg.sv
// Purpose: Shared constants of the quad serial host front end
// Assumes: 8-bit host bus, four channels, one system clock
// Notes:   Offsets are byte addresses on the host address lines
package quhsr_pkg;

    localparam int NUM_CH    = 4;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int REG_W     = 4;
    localparam int TMR_WIDTH = 16;

    // Address fields
    localparam int ADDR_DEV_BIT  = 7;  // 1: device-level space
    localparam int ADDR_RSV_BIT  = 6;  // 1 with dev bit 0: reserved
    localparam int ADDR_CH_HI    = 5;
    localparam int ADDR_CH_LO    = 4;

    // Per-channel register offsets (low nibble)
    localparam logic [3:0] OFF_MODEM_CTRL   = 4'h0;
    localparam logic [3:0] OFF_FEATURE_CTRL = 4'h1;
    localparam logic [3:0] OFF_MODEM_STAT   = 4'h2;
    localparam logic [3:0] OFF_LINE_CTRL    = 4'h3;

    // Device-level register offsets
    localparam logic [7:0] OFF_BCAST_CTRL = 8'h80;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h81;
    localparam logic [7:0] OFF_TMR_CTRL   = 8'h82;
    localparam logic [7:0] OFF_TMR_LSB    = 8'h83;
    localparam logic [7:0] OFF_TMR_MSB    = 8'h84;

    // Field positions
    localparam int MCR_TERM_BIT  = 0;
    localparam int MCR_SEND_BIT  = 1;
    localparam int MCR_IR_BIT    = 6;
    localparam int FEATURE_CONTROL_REG_POL_BIT  = 4;
    localparam int LINE_MARK_BIT = 0;
    localparam int BCAST_BIT     = 0;
    localparam int TMR_EN_BIT    = 0;
    localparam int TMR_EXT_BIT   = 1;
    localparam int TMR_CLR_BIT   = 2;
    localparam int MSR_CTS_BIT   = 4;
    localparam int MSR_DSR_BIT   = 5;
    localparam int MSR_RI_BIT    = 6;
    localparam int MSR_CD_BIT    = 7;

    // Reset values
    localparam logic [7:0] MCR_RST  = 8'h00;
    localparam logic [7:0] FEATURE_CONTROL_REG_RST = 8'h00;
    localparam logic [7:0] LINE_RST = 8'h01;  // Line rests at mark
    localparam logic [7:0] ZERO8    = 8'h00;

endpackage : quhsr_pkg

//--- common/quhsr_chan_if.sv
// Purpose: Register access path from the host decoder to one channel
// Assumes: Single clock domain, write strobe is a one-cycle pulse
// Notes:   Read data is combinational from the channel registers
`timescale 1ns/1ps
interface quhsr_chan_if;
    import quhsr_pkg::*;
    logic              wr_en;       // One-cycle write pulse
    logic [REG_W-1:0]  reg_addr;    // Channel register offset
    logic [DATA_W-1:0] wdata;       // Write data
    logic              strap_load;  // Reload defaults, sample strap
    logic              strap;       // Infrared strap level
    logic [DATA_W-1:0] rdata;       // Register read data

    modport dec  (output wr_en, reg_addr, wdata, strap_load, strap,
                  input  rdata);
    modport chan (input  wr_en, reg_addr, wdata, strap_load, strap,
                  output rdata);
endinterface : quhsr_chan_if

//--- verilog/quhsr_chan.sv
// Purpose: One serial channel's control registers and pin levels
// Assumes: Host writes arrive as single-cycle pulses
// Notes:   All pin outputs are registered, one cycle after the cause
`timescale 1ns/1ps
module quhsr_chan
    import quhsr_pkg::*;
(
    input  wire logic  clk_sys,           // System clock
    input  wire logic  resetn,            // Async reset, active low
    quhsr_chan_if.chan bus,               // Register access
    input  wire logic  serial_in,         // Receive line
    input  wire logic  send_clear_n,      // Clear to send, low active
    input  wire logic  set_ready_n,       // Set ready, low active
    input  wire logic  carrier_detect_n,  // Carrier, low active
    input  wire logic  ring_indicator_n,  // Ring, low active
    output logic       serial_out,        // Transmit line
    output logic       send_request_n,    // Request to send, low active
    output logic       terminal_ready_n,  // Terminal ready, low active
    output logic       rx_mark            // Decoded receive level
);

    logic [DATA_W-1:0] mcr_r;
    logic [DATA_W-1:0] feature_control_reg_r;
    logic [DATA_W-1:0] line_r;
    logic [DATA_W-1:0] msr;

    // Control registers; reload also samples the strap
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mcr_r  <= MCR_RST;
            feature_control_reg_r <= FEATURE_CONTROL_REG_RST;
            line_r <= LINE_RST;
        end else if (bus.strap_load) begin
            mcr_r              <= MCR_RST;
            mcr_r[MCR_IR_BIT]  <= bus.strap;
            feature_control_reg_r             <= FEATURE_CONTROL_REG_RST;
            line_r             <= LINE_RST;
        end else if (bus.wr_en) begin
            if (bus.reg_addr == OFF_MODEM_CTRL)   mcr_r  <= bus.wdata;
            if (bus.reg_addr == OFF_FEATURE_CTRL) feature_control_reg_r <= bus.wdata;
            if (bus.reg_addr == OFF_LINE_CTRL)    line_r <= bus.wdata;
        end
    end

    // Pin levels; infrared idles low, so the mark level is inverted
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serial_out       <= 1'b1;
            send_request_n   <= 1'b1;
            terminal_ready_n <= 1'b1;
            rx_mark          <= 1'b1;
        end else begin
            serial_out <= mcr_r[MCR_IR_BIT] ? ~line_r[LINE_MARK_BIT]
                                            : line_r[LINE_MARK_BIT];
            send_request_n   <= ~mcr_r[MCR_SEND_BIT];
            terminal_ready_n <= ~mcr_r[MCR_TERM_BIT];
            if (!mcr_r[MCR_IR_BIT])
                rx_mark <= serial_in;
            else
                rx_mark <= feature_control_reg_r[FEATURE_CONTROL_REG_POL_BIT] ? serial_in
                                                : ~serial_in;
        end
    end

    // Modem inputs read back active high as general purpose bits
    always_comb begin
        msr              = ZERO8;
        msr[MSR_CTS_BIT] = ~send_clear_n;
        msr[MSR_DSR_BIT] = ~set_ready_n;
        msr[MSR_RI_BIT]  = ~ring_indicator_n;
        msr[MSR_CD_BIT]  = ~carrier_detect_n;
    end

    always_comb begin
        unique case (bus.reg_addr)
            OFF_MODEM_CTRL:   bus.rdata = mcr_r;
            OFF_FEATURE_CTRL: bus.rdata = feature_control_reg_r;
            OFF_MODEM_STAT:   bus.rdata = msr;
            OFF_LINE_CTRL:    bus.rdata = line_r;
            default:          bus.rdata = ZERO8;
        endcase
    end

    AST_TX_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
        serial_out == ($past(mcr_r[MCR_IR_BIT]) ^
                       $past(line_r[LINE_MARK_BIT])))
        else $error("transmit idle level wrong for mode");

    AST_RX_POL: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(mcr_r[MCR_IR_BIT]) && !$past(feature_control_reg_r[FEATURE_CONTROL_REG_POL_BIT])
        |-> rx_mark == !$past(serial_in))
        else $error("infrared receive polarity wrong");

    AST_MODEM_OUT: assert property (@(posedge clk_sys) disable iff (!resetn)
        bus.wr_en && bus.reg_addr == OFF_MODEM_CTRL && !bus.strap_load
        |-> ##2 send_request_n == !$past(bus.wdata[MCR_SEND_BIT], 2))
        else $error("send request not active low of written bit");

endmodule : quhsr_chan

//--- dv/quhsr_host_model.sv
// Purpose: Host processor model on the 8-bit parallel bus
// Assumes: Bus signals change at the falling edge of clk_sys
// Notes:   Released address and data show the inverse, never a hold
`timescale 1ns/1ps
module quhsr_host_model
    import quhsr_pkg::*;
(
    input  wire logic              clk_sys,         // System clock
    input  wire logic [DATA_W-1:0] data_out,        // Device read data
    input  wire logic              data_oe,         // Device drives bus
    output logic                   chip_sel_n,      // Chip select
    output logic                   read_strobe_n,   // Read strobe
    output logic                   write_strobe_n,  // Write or R-W pin
    output logic                   bus_style,       // Bus style pick
    output logic      [ADDR_W-1:0] addr,            // Address lines
    output logic      [DATA_W-1:0] data_in          // Write data
);
    // Idle bus, first style, from time zero
    initial begin
        bus_style = 1'b1;
        addr      = 8'h00;
        data_in   = 8'h00;
        idle();
    end

    // Release the bus; stale lines flip so no value lingers
    task automatic idle();
        chip_sel_n     = 1'b1;
        read_strobe_n  = 1'b1;
        write_strobe_n = 1'b1;
        addr           = ~addr;
        data_in        = ~data_in;
    endtask : idle

    // Bus style changes only while the bus rests
    task automatic set_style(input logic s);
        bus_style = s;
    endtask : set_style

    // Write held two edges, then a cycle of idle before the next
    task automatic wr(input logic sel, input logic [7:0] a,
                      input logic [7:0] d);
        @(negedge clk_sys);
        chip_sel_n     = ~sel;
        write_strobe_n = 1'b0;
        addr           = a;
        data_in        = d;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        idle();
    endtask : wr

    // Read held until the device drives, data taken at that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        chip_sel_n     = 1'b0;
        read_strobe_n  = ~bus_style;
        write_strobe_n = 1'b1;
        addr           = a;
        repeat (8) begin
            @(posedge clk_sys);
            if (data_oe === 1'b1)
                break;
        end
        // No drive within the limit hands back unknown, so it mismatches
        d = (data_oe === 1'b1) ? data_out : 8'hxx;
        @(negedge clk_sys);
        idle();
    endtask : rd
endmodule : quhsr_host_model

//--- dv/tb_quad_uart_host_select_reset.sv
// Purpose: Self-checking bench of the quad serial host front end
// Assumes: Host model drives the bus, bench drives the pins
// Notes:   Expected pin levels are worked out from the channel fields
`timescale 1ns/1ps
module tb_quad_uart_host_select_reset;
    import quhsr_pkg::*;
    logic       clk_sys, resetn, strap, tclk;
    logic [3:0] rx, cts_n, dsr_n, cd_n, ri_n, m;
    logic [7:0] rv;
    wire        cs_n, rd_n, wr_n, style, oe, bcast;
    wire  [7:0] addr, din, dout;
    wire  [3:0] txo, rts_n, dtr_n, mark;
    int         n_mismatch = 0;
    int         n_tests    = 0;
    int         cyc        = 0;

    quhsr_host_front DUT (.clk_sys(clk_sys), .resetn(resetn),
        .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .bus_style(style), .addr(addr), .data_in(din), .data_out(dout),
        .data_oe(oe), .infrared_strap(strap), .timer_ext_clock(tclk),
        .serial_in_ch(rx), .send_clear_n_ch(cts_n),
        .set_ready_n_ch(dsr_n), .carrier_detect_n_ch(cd_n),
        .ring_indicator_n_ch(ri_n), .serial_out_ch(txo),
        .send_request_n_ch(rts_n), .terminal_ready_n_ch(dtr_n),
        .rx_mark_ch(mark), .bcast_mode(bcast));
    quhsr_host_model host (.clk_sys(clk_sys), .data_out(dout),
        .data_oe(oe), .chip_sel_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .bus_style(style), .addr(addr),
        .data_in(din));

    // Clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the run's fewer than two hundred cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic settle();
        repeat (3) @(negedge clk_sys);
    endtask : settle

    // Reset held ten cycles, well past the minimum pulse
    task automatic hw_reset();
        @(negedge clk_sys);
        resetn = 1'b0;
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        settle();
    endtask : hw_reset

    task automatic t_reset();
        chk("txo", 8'h0f, {4'h0, txo});
        chk("rts", 8'h0f, {4'h0, rts_n});
        chk("dtr", 8'h0f, {4'h0, dtr_n});
        chk("oe_bc", 8'h00, {6'h0, oe, bcast});
    endtask : t_reset

    // Timer counts five external edges only
    task automatic t_timer();
        host.wr(1'b1, OFF_TMR_CTRL, 8'h03);
        repeat (5) begin
            tclk = 1'b1;
            settle();
            tclk = 1'b0;
            settle();
        end
        host.rd(OFF_TMR_LSB, rv);
        chk("tmr_lsb", 8'h05, rv);
        host.rd(OFF_TMR_MSB, rv);
        chk("tmr_msb", 8'h00, rv);
        host.wr(1'b1, OFF_TMR_CTRL, 8'h06);
        host.rd(OFF_TMR_LSB, rv);
        chk("tmr_clr", 8'h00, rv);
    endtask : t_timer

    // Channels one by one, then ignored and reserved writes
    task automatic t_select();
        m = 4'h0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            host.wr(1'b1, {2'b00, ch[1:0], OFF_MODEM_CTRL}, 8'h03);
            m[ch] = 1'b1;
            settle();
            chk("rts", {4'h0, ~m}, {4'h0, rts_n});
        end
        host.wr(1'b0, 8'h00, 8'h00);
        host.wr(1'b1, 8'h40, 8'h00);
        host.wr(1'b1, 8'h70, 8'h00);
        settle();
        chk("dtr", 8'h00, {4'h0, dtr_n});
        host.rd(8'h20, rv);
        chk("mcr2", 8'h03, rv);
        host.rd(8'h40, rv);
        chk("rsv", 8'h00, rv);
    endtask : t_select

    // One write lands in all four channels
    task automatic t_bcast();
        host.wr(1'b1, OFF_BCAST_CTRL, 8'h01);
        settle();
        chk("bcast", 8'h01, {7'h0, bcast});
        host.wr(1'b1, 8'h10, 8'h02);
        settle();
        chk("rts", 8'h00, {4'h0, rts_n});
        chk("dtr", 8'h0f, {4'h0, dtr_n});
        host.wr(1'b1, OFF_BCAST_CTRL, 8'h00);
        host.rd(8'h30, rv);
        chk("mcr3", 8'h02, rv);
    endtask : t_bcast

    // Second bus style; modem inputs read as active high
    task automatic t_modem();
        @(negedge clk_sys);
        host.set_style(1'b0);
        cts_n = 4'he;
        ri_n  = 4'he;
        cd_n  = 4'hd;
        settle();
        host.rd(8'h02, rv);
        chk("msr0", 8'h50, rv);
        host.rd(8'h12, rv);
        chk("msr1", 8'h80, rv);
        host.wr(1'b1, 8'h00, 8'h01);
        settle();
        chk("dtr", 8'h0e, {4'h0, dtr_n});
        host.set_style(1'b1);
    endtask : t_modem

    // Soft reset of channels 0 and 2 picks up the strap
    task automatic t_ir();
        strap = 1'b1;
        host.wr(1'b1, OFF_SOFT_RESET, 8'h05);
        rx[0] = 1'b0;
        settle();
        chk("txo", 8'h0a, {4'h0, txo});
        host.rd(8'h00, rv);
        chk("mcr0", 8'h40, rv);
        chk("mark", 8'h01, {7'h0, mark[0]});
        rx[0] = 1'b1;
        settle();
        chk("mark", 8'h00, {7'h0, mark[0]});
        host.wr(1'b1, 8'h01, 8'h10);
        settle();
        chk("mark", 8'h01, {7'h0, mark[0]});
    endtask : t_ir

    task automatic t_hwrst();
        hw_reset();
        chk("txo", 8'h00, {4'h0, txo});
        chk("rts", 8'h0f, {4'h0, rts_n});
    endtask : t_hwrst

    task automatic end_sim();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Pins idle at time zero, then the scenarios in turn
    initial begin
        resetn = 1'b0;
        strap  = 1'b0;
        tclk   = 1'b0;
        rx     = 4'hf;
        cts_n  = 4'hf;
        dsr_n  = 4'hf;
        cd_n   = 4'hf;
        ri_n   = 4'hf;
        hw_reset();
        t_reset();
        t_timer();
        t_select();
        t_bcast();
        t_modem();
        t_ir();
        t_hwrst();
        end_sim();
    end
endmodule : tb_quad_uart_host_select_reset
